/* verilog/ief_flags.sv */
// Event-flag register of a two-wire bus controller with its buffer states.
`timescale 1ns/1ps
`include "ief_params.svh"
module ief_flags
  import ief_pkg::*;
#(
  parameter logic [19:0] SCL_TO_BASE  = `IEF_SCL_TO_BASE,
  parameter logic [19:0] IDLE_TO_BASE = `IEF_IDLE_TO_BASE
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // Register port.
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [31:0]     reg_rdata,
  // Bus lines, asynchronous to the clock.
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  // Events from the protocol engine, on the same clock.
  input  wire logic       start_sent,
  input  wire logic       stop_sending,
  input  wire logic       stop_sent,
  input  wire logic       arb_lost,
  input  wire logic       ack_rcvd,
  input  wire logic       nack_rcvd,
  input  wire logic       addr_accept,
  input  wire logic       hold_active,
  input  wire logic       byte_active,
  input  wire logic       engine_error,
  input  wire logic       shift_empty,
  input  wire logic       rx_push,
  input  wire ief_byte_t  rx_byte,
  input  wire logic       tx_take,
  // Towards the protocol engine.
  output ief_byte_t       tx_byte,
  output logic            tx_avail,
  output logic            xfer_abort,
  output logic            bus_busy
);
  logic       scl_s;
  logic       start_det;
  logic       stop_det;
  ief_flags_t flags_q;
  ief_flags_t hw_set;
  ief_flags_t sw_set;
  ief_flags_t sw_clr;
  ief_flags_t flags_view;
  logic [7:0] ctrl_q;
  ief_byte_t  rx_data_q;
  logic       rx_full_q;
  ief_byte_t  tx_data_q;
  logic       tx_full_q;
  logic       busy_q;
  logic       abort_q;
  logic       hold_p_q;
  logic       stop_lost_q;
  logic [31:0] rdata_q;
  logic [19:0] scl_cnt_q;
  logic [19:0] idle_cnt_q;
  logic [19:0] scl_limit;
  logic [19:0] idle_limit;
  logic       scl_to;
  logic       idle_to;
  logic       bus_err;
  logic       wr_ctrl;
  logic       wr_tx;
  logic       wr_set;
  logic       wr_clr;
  logic       rd_pop;
  ief_to_sel_t scl_sel;
  ief_to_sel_t idle_sel;

  ief_line_sync u_sync (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .scl_s     (scl_s),
    .sda_s     (),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  // ========================================================================
  // Register decode.
  assign wr_ctrl = reg_wr & (reg_addr == `IEF_OFF_CTRL);
  assign wr_tx   = reg_wr & (reg_addr == `IEF_OFF_TX_DATA);
  assign wr_set  = reg_wr & (reg_addr == `IEF_OFF_FLAG_SET);
  assign wr_clr  = reg_wr & (reg_addr == `IEF_OFF_FLAG_CLR);
  assign rd_pop  = reg_rd & (reg_addr == `IEF_OFF_RX_POP);

  // Control register holds the two timeout selections.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_q <= `IEF_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata[7:0];
    end
  end

  assign scl_sel  = ctrl_q[`IEF_CTRL_SCLTO_LSB +: 2];
  assign idle_sel = ctrl_q[`IEF_CTRL_IDLETO_LSB +: 2];

  // ========================================================================
  // Timeouts: a selection of 1, 2 or 3 gives one, two or four base lengths.
  assign scl_limit  = SCL_TO_BASE << (scl_sel - 2'h1);
  assign idle_limit = IDLE_TO_BASE << (idle_sel - 2'h1);

  // Clock-low counter fires once per low stretch that outlasts the limit.
  always_ff @(posedge clock) begin
    if (sys_rst || scl_s || scl_sel == `IEF_TO_SEL_OFF) begin
      scl_cnt_q <= '0;
    end else if (scl_cnt_q != scl_limit) begin
      scl_cnt_q <= scl_cnt_q + 20'h0_0001;
    end
  end
  assign scl_to = (scl_sel != `IEF_TO_SEL_OFF) && !scl_s
                  && (scl_cnt_q == scl_limit - 20'h0_0001); // [R2]

  // Idle counter runs while the bus is busy but the clock rests high.
  always_ff @(posedge clock) begin
    if (sys_rst || !scl_s || !busy_q || idle_sel == `IEF_TO_SEL_OFF) begin
      idle_cnt_q <= '0;
    end else begin
      idle_cnt_q <= idle_cnt_q + 20'h0_0001;
    end
  end
  assign idle_to = busy_q && scl_s && (idle_sel != `IEF_TO_SEL_OFF)
                   && (idle_cnt_q == idle_limit - 20'h0_0001); // [R3]

  // ========================================================================
  // A bus condition in the middle of a byte is a misplaced one.
  assign bus_err = engine_error | ((start_det | stop_det) & byte_active);

  // Busy tracks the bus; an idle timeout or bus error frees it again.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
    end else if (stop_det || idle_to || bus_err) begin
      busy_q <= 1'b0; // [R7]
    end else if (start_det) begin
      busy_q <= 1'b1;
    end
  end

  // Abort pulse tells the engine to drop the transfer and release lines.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      abort_q <= 1'b0;
    end else begin
      abort_q <= bus_err; // [R7]
    end
  end

  // Remember a lost arbitration while our stop goes out.
  always_ff @(posedge clock) begin
    if (sys_rst || !stop_sending) begin
      stop_lost_q <= 1'b0;
    end else if (arb_lost) begin
      stop_lost_q <= 1'b1; // [R9]
    end
  end

  // Hold edge detect; only the start of a hold is an event.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hold_p_q <= 1'b0;
    end else begin
      hold_p_q <= hold_active;
    end
  end

  // ========================================================================
  // Receive buffer, one byte; the pop read empties it.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_full_q <= 1'b0;
      rx_data_q <= '0;
    end else if (rx_push) begin
      rx_full_q <= 1'b1; // [R11]
      rx_data_q <= rx_byte;
    end else if (rd_pop) begin
      rx_full_q <= 1'b0; // [R11]
    end
  end

  // Transmit buffer, one byte; a write into a full buffer is dropped.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_full_q <= 1'b0;
      tx_data_q <= '0;
    end else if (wr_tx && !tx_full_q) begin
      tx_full_q <= 1'b1; // [R12]
      tx_data_q <= reg_wdata[7:0];
    end else if (tx_take || bus_err) begin
      tx_full_q <= 1'b0; // [R12]
    end
  end

  // ========================================================================
  // Hardware events, one bit per flag.
  always_comb begin
    hw_set = '0;
    hw_set[`IEF_B_STOP_SEEN]  = stop_det; // [R1]
    hw_set[`IEF_B_SCL_TO]     = scl_to; // [R2]
    hw_set[`IEF_B_IDLE_TO]    = idle_to; // [R3]
    hw_set[`IEF_B_RX_UF]      = rd_pop & ~rx_full_q; // [R4]
    hw_set[`IEF_B_TX_OF]      = wr_tx & tx_full_q; // [R5]
    hw_set[`IEF_B_HELD]       = hold_active & ~hold_p_q; // [R6]
    hw_set[`IEF_B_BUS_ERR]    = bus_err; // [R7]
    hw_set[`IEF_B_ARB_LOST]   = arb_lost; // [R8]
    hw_set[`IEF_B_MASTER_STOP_SENT_FLAG]      = stop_sent & ~stop_lost_q & ~arb_lost; // [R9]
    hw_set[`IEF_B_NACK]       = nack_rcvd; // [R10]
    hw_set[`IEF_B_ACK]        = ack_rcvd; // [R10]
    hw_set[`IEF_B_SHIFT_DONE] = shift_empty & ~tx_full_q; // [R13]
    hw_set[`IEF_B_ADDR]       = addr_accept; // [R14]
    hw_set[`IEF_B_RESTART]    = start_det & busy_q; // [R15]
    hw_set[`IEF_B_START]      = start_sent; // [R16]
  end

  // Software set and clear reach only the sticky event bits.
  assign sw_set = wr_set ? reg_wdata[16:0] & `IEF_STICKY_MASK : '0; // [R18]
  assign sw_clr = wr_clr ? reg_wdata[16:0] & `IEF_STICKY_MASK : '0; // [R19]

  // Sticky flags: clear first, then set, so a same-cycle event survives.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      flags_q <= `IEF_FLAGS_RESET; // [R17]
    end else begin
      flags_q <= ((flags_q & ~sw_clr) | sw_set | hw_set)
                 & `IEF_STICKY_MASK; // [R20]
    end
  end

  // Buffer flags are live views of the buffer state, not stored events.
  always_comb begin
    flags_view = flags_q;
    flags_view[`IEF_B_RX_VALID] = rx_full_q; // [R11]
    flags_view[`IEF_B_TX_EMPTY] = ~tx_full_q; // [R12]
  end

  // ========================================================================
  // Read data stands one cycle after the strobe; reserved bits read zero.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        `IEF_OFF_CTRL:   rdata_q <= {24'h00_0000, ctrl_q};
        `IEF_OFF_RX_POP: rdata_q <= {24'h00_0000, rx_data_q};
        `IEF_OFF_FLAGS:  rdata_q <= {15'h0000, flags_view}; // [R17]
        default:         rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata  = rdata_q;
  assign tx_byte    = tx_data_q;
  assign tx_avail   = tx_full_q;
  assign xfer_abort = abort_q;
  assign bus_busy   = busy_q;
endmodule

/* include/ief_params.svh */
// Constants of the two-wire bus event-flag block.
//
// Behaviour
// [R1] Stop-seen flag, bit 16, sets on any bus stop, even as a bystander.
// [R2] Clock-low timeout flag, bit 15, sets on each clock-low timeout expiry.
// [R3] Idle timeout flag, bit 14, sets on each bus idle timeout expiry.
// [R4] Receive underflow flag, bit 13, sets when popping an empty receive buffer.
// [R5] Transmit overflow flag, bit 12, sets on a write into a full buffer.
// [R6] Bus-held flag, bit 11, sets when the controller starts holding the bus.
// [R7] Bus error sets bit 10, recovers automatically and aborts the transfer.
// [R8] Arbitration-lost flag, bit 9, sets whenever arbitration is lost.
// [R9] Master-stop flag, bit 8, sets only after a stop sent without losing.
// [R10] Bit 7 sets on a received not-acknowledge, bit 6 on an acknowledge.
// [R11] Receive-valid, bit 5, is high while receive data waits; read clears.
// [R12] Transmit-empty, bit 4, resets to 1; set when empty, cleared on write.
// [R13] Transfer-complete, bit 3, sets when shifter and buffer are both empty.
// [R14] Address-accepted, bit 2, sets on own or general call address.
// [R15] Repeated-start flag, bit 1, sets on every repeated start on the bus.
// [R16] Start flag, bit 0, sets when this device has sent a start.
// [R17] Flags are read-only; all reset 0 except transmit-empty; 31:17 reserved.
// [R18] Writing 1 to the set register forces a flag high; 0 leaves it.
// [R19] Writing 1 to the clear register clears the matching flags.
// [R20] Event flags stick until cleared; a set in the clear cycle wins.
`ifndef IEF_PARAMS_SVH
`define IEF_PARAMS_SVH

// ==========================================================================
// Register offsets (byte addresses).
`define IEF_OFF_CTRL      12'h000
`define IEF_OFF_RX_POP    12'h01C
`define IEF_OFF_TX_DATA   12'h024
`define IEF_OFF_FLAGS     12'h028
`define IEF_OFF_FLAG_SET  12'h02C
`define IEF_OFF_FLAG_CLR  12'h030

// ==========================================================================
// Flag bit positions.
`define IEF_B_STOP_SEEN   16
`define IEF_B_SCL_TO      15
`define IEF_B_IDLE_TO     14
`define IEF_B_RX_UF       13
`define IEF_B_TX_OF       12
`define IEF_B_HELD        11
`define IEF_B_BUS_ERR     10
`define IEF_B_ARB_LOST    9
`define IEF_B_MASTER_STOP_SENT_FLAG       8
`define IEF_B_NACK        7
`define IEF_B_ACK         6
`define IEF_B_RX_VALID    5
`define IEF_B_TX_EMPTY    4
`define IEF_B_SHIFT_DONE  3
`define IEF_B_ADDR        2
`define IEF_B_RESTART     1
`define IEF_B_START       0
`define IEF_FLAG_MSB      16

// Flags that software may set or clear (bits 5 and 4 track buffer state).
`define IEF_STICKY_MASK   17'h1_FFCF
`define IEF_FLAGS_RESET   17'h0_0000

// ==========================================================================
// Control register fields and timeout scaling.
`define IEF_CTRL_SCLTO_LSB 0
`define IEF_CTRL_IDLETO_LSB 4
`define IEF_CTRL_RESET    8'h00
`define IEF_TO_SEL_OFF    2'h0
`define IEF_TO_CNT_W      20
`define IEF_SCL_TO_BASE   20'h0_1000
`define IEF_IDLE_TO_BASE  20'h0_0400

`endif

/* include/ief_pkg.sv */
// Types shared by the two-wire bus event-flag block.
package ief_pkg;
  typedef logic [16:0] ief_flags_t;
  typedef logic [7:0]  ief_byte_t;
  typedef logic [1:0]  ief_to_sel_t;
endpackage

/* verilog/ief_line_sync.sv */
// Bus line synchroniser and start and stop condition detector.
`timescale 1ns/1ps
module ief_line_sync (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_s,
  output logic      sda_s,
  output logic      start_det,
  output logic      stop_det
);
  logic scl_m_q;
  logic sda_m_q;
  logic scl_s_q;
  logic sda_s_q;
  logic sda_p_q;

  // ========================================================================
  // Two flops per line, and a third on data for edge detection; the first one is read by the second alone.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scl_m_q <= 1'b1;
      sda_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= scl_in;
      sda_m_q <= sda_in;
      scl_s_q <= scl_m_q;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  // Data edges while the clock line stays high mark bus conditions.
  assign scl_s     = scl_s_q;
  assign sda_s     = sda_s_q;
  assign start_det = scl_s_q & sda_p_q & ~sda_s_q;
  assign stop_det  = scl_s_q & ~sda_p_q & sda_s_q;
endmodule

/* verification/ief_flags_sva.sv */
// Port-level assertions for the two-wire bus event-flag block.
`timescale 1ns/1ps
module ief_flags_chk (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic [11:0] reg_addr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        start_sent,
  input wire logic        arb_lost,
  input wire logic        ack_rcvd,
  input wire logic        nack_rcvd,
  input wire logic        addr_accept,
  input wire logic        engine_error,
  input wire logic        tx_avail,
  input wire logic        xfer_abort,
  input wire logic        bus_busy
);
  // ==========================================================
  // Checks, all in the one clock domain.
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic rd_flags;
  // A read of the flag word; its data stand one cycle later.
  assign rd_flags = reg_rd && reg_addr == 12'h028;
  // An event must already show to a read issued the very next cycle.
  property ev_seen(logic ev, int b);
    ev ##1 rd_flags |=> reg_rdata[b];
  endproperty
  start_flag_a: assert property (ev_seen(start_sent, 0))
    else $error("start flag missing");
  arb_flag_a: assert property (ev_seen(arb_lost, 9))
    else $error("arbitration flag missing");
  ack_flag_a: assert property (ev_seen(ack_rcvd, 6))
    else $error("ack flag missing");
  nack_flag_a: assert property (ev_seen(nack_rcvd, 7))
    else $error("nack flag missing");
  addr_flag_a: assert property (ev_seen(addr_accept, 2))
    else $error("address flag missing");
  error_flag_a: assert property (ev_seen(engine_error, 10))
    else $error("bus error flag missing");
  abort_pulse_a: assert property (engine_error |=> xfer_abort)
    else $error("no abort after bus error");
  busy_drop_a: assert property (engine_error |=> !bus_busy)
    else $error("busy kept after bus error");
  // Empty flag is live buffer state, so it mirrors the full marker.
  tx_empty_a: assert property (
    rd_flags |=> reg_rdata[4] == !$past(tx_avail))
    else $error("empty flag wrong");
  reserved_zero_a: assert property (reg_rdata[31:17] == 15'h0000)
    else $error("reserved bits set");
  set_reads_zero_a: assert property (
    reg_rd && reg_addr == 12'h02C |=> reg_rdata == 32'h0000_0000)
    else $error("set register read not zero");
  cover property (rd_flags ##1 reg_rdata[4]);
  cover property (engine_error ##1 xfer_abort);
  cover property ($rose(tx_avail));
endmodule

bind ief_flags ief_flags_chk u_chk (
  .clock, .sys_rst, .reg_addr, .reg_rd, .reg_rdata, .start_sent,
  .arb_lost, .ack_rcvd, .nack_rcvd, .addr_accept, .engine_error,
  .tx_avail, .xfer_abort, .bus_busy);

/* verification/ief_bus_model.sv */
// Other stations on the two-wire bus; both lines are pulled up.
`timescale 1ns/1ps
module ief_bus_model (
  output logic scl,
  output logic sda
);
  // ==========================================================
  // Line sequences. The clock stands high outside frames.
  localparam time HALF = 32ns;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Start: data falls with the clock high, then the clock is held low.
  task automatic begin_frame();
    sda = 1'b0;
    #HALF scl = 1'b0;
  endtask
  // Repeated start from a low clock; leaves the clock high.
  task automatic again_frame();
    sda = 1'b1;
    #HALF scl = 1'b1;
    #HALF sda = 1'b0;
  endtask
  // Stop from a high clock and low data, avoiding a new low stretch.
  task automatic end_frame();
    sda = 1'b1;
    #HALF;
  endtask
endmodule

/* verification/testbench.sv */
// Self-checking bench for the two-wire bus event-flag block.
`timescale 1ns/1ps
module testbench
  import ief_pkg::*;
();
  // ==========================================================
  // Stimulus and checks.
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata, rd_v;
  logic [8:0]  ev = 9'h000;
  logic        stop_sending = 1'b0;
  logic        byte_active = 1'b0;
  logic        rx_push = 1'b0;
  logic        tx_take = 1'b0;
  ief_byte_t   rx_byte = 8'h00;
  ief_byte_t   tx_byte;
  logic        scl_in, sda_in, tx_avail, xfer_abort, bus_busy;
  int          num_errors = 0;
  int          total_checks = 0;
  int          fbit [8] = '{0, 9, 6, 7, 2, 10, 11, 3};

  // Short timeout bases let both timeouts fire within the bus phase of under a hundred cycles.
  ief_flags #(.SCL_TO_BASE(20'h0_0008), .IDLE_TO_BASE(20'h0_0008)) dut (
    .clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .scl_in, .sda_in, .start_sent(ev[0]), .stop_sending, .stop_sent(ev[8]),
    .arb_lost(ev[1]), .ack_rcvd(ev[2]), .nack_rcvd(ev[3]),
    .addr_accept(ev[4]), .hold_active(ev[6]), .byte_active,
    .engine_error(ev[5]), .shift_empty(ev[7]), .rx_push, .rx_byte,
    .tx_take, .tx_byte, .tx_avail, .xfer_abort, .bus_busy);
  ief_bus_model bus (.scl(scl_in), .sda(sda_in));

  initial begin
    forever #2.5 clock = ~clock;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [11:0] a);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask
  task automatic flags(input logic [31:0] exp);
    rd(12'h028);
    chk(rd_v, exp);
  endtask
  // With rd_now the flag word is read in the cycle right after the event.
  task automatic pulse(input logic [8:0] v, input bit rd_now = 1'b0);
    @(posedge clock);
    ev <= v;
    @(posedge clock);
    ev <= 9'h000;
    if (rd_now) begin
      reg_rd   <= 1'b1;
      reg_addr <= 12'h028;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata;
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #20us;
    num_errors++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    flags(32'h0000_0010);
    wr(12'h028, 32'h0001_FFFF);
    flags(32'h0000_0010);
    rd(12'h100);
    chk(rd_v, 32'h0000_0000);
    wr(12'h02C, 32'h0001_FFFF);
    flags(32'h0001_FFDF);
    wr(12'h030, 32'h0001_FFFF);
    flags(32'h0000_0010);
    for (int i = 0; i < 8; i++) begin
      pulse(9'h001 << i, 1'b1);
      chk(rd_v, 32'h10 | 32'h1<<fbit[i]);
      wr(12'h030, 32'h0001_FFFF);
    end
    // Clear and acknowledge land on one edge; the event must survive.
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= 12'h030;
    reg_wdata <= 32'h0000_0040;
    ev        <= 9'h004;
    @(posedge clock);
    reg_wr <= 1'b0;
    ev     <= 9'h000;
    flags(32'h0000_0050);
    wr(12'h030, 32'h0001_FFFF);
    stop_sending <= 1'b1;
    pulse(9'h100);
    stop_sending <= 1'b0;
    flags(32'h0000_0110);
    wr(12'h030, 32'h0001_FFFF);
    stop_sending <= 1'b1;
    pulse(9'h002);
    pulse(9'h100);
    stop_sending <= 1'b0;
    flags(32'h0000_0210);
    wr(12'h030, 32'h0001_FFFF);
    wr(12'h024, 32'h0000_00A5);
    flags(32'h0000_0000);
    wr(12'h024, 32'h0000_003C);
    flags(32'h0000_1000);
    chk({24'h00_0000, tx_byte}, 32'h0000_00A5);
    @(posedge clock);
    tx_take <= 1'b1;
    @(posedge clock);
    tx_take <= 1'b0;
    flags(32'h0000_1010);
    rd(12'h01C);
    flags(32'h0000_3010);
    @(posedge clock);
    rx_push <= 1'b1;
    rx_byte <= 8'h5A;
    @(posedge clock);
    rx_push <= 1'b0;
    flags(32'h0000_3030);
    rd(12'h01C);
    chk(rd_v, 32'h0000_005A);
    flags(32'h0000_3010);
    // Bus traffic from another master, both timeouts armed.
    wr(12'h030, 32'h0001_FFFF);
    wr(12'h000, 32'h0000_0011);
    bus.begin_frame();
    #150;
    bus.again_frame();
    #150;
    bus.end_frame();
    #50;
    flags(32'h0001_C012);
    // A start in mid-byte is a bus error that also drops the queued byte.
    wr(12'h030, 32'h0001_FFFF);
    byte_active <= 1'b1;
    wr(12'h024, 32'h0000_0077);
    bus.begin_frame();
    #100;
    flags(32'h0000_8410);
    chk({30'h0000_0000, tx_avail, bus_busy}, 32'h0000_0000);
    wrap_up();
  end
endmodule
